// File: include/console_pkg.sv
package console_pkg;
   // Boot memory map
   localparam logic [15:0] BAUD_DIV_ADDR   = 16'h0008;
   localparam logic [15:0] AUTO_SIG_ADDR   = 16'h2000;
   localparam logic [15:0] AUTO_ENTRY_ADDR = 16'h2001;
   localparam logic [15:0] AUTO_END_ADDR   = 16'h7FFF;
   localparam logic [15:0] MONITOR_ENTRY   = 16'h0000;
   localparam logic [7:0]  AUTO_SIGNATURE  = 8'hA5;
   // Divisor codes
   localparam logic [7:0] DIV_57600 = 8'hFF;
   localparam logic [7:0] DIV_28800 = 8'hFE;
   localparam logic [7:0] DIV_19200 = 8'hFD;
   localparam logic [7:0] DIV_9600  = 8'hFA;
   localparam logic [7:0] DIV_4800  = 8'hF4;
   localparam logic [7:0] DIV_2400  = 8'hE8;
   localparam logic [7:0] DIV_1200  = 8'hD0;
   localparam logic [7:0] DIV_600   = 8'hA0;
   // Clock and oversampling
   localparam int          CLK_HZ      = 200000000;
   localparam int          OVERSAMPLE  = 16;
   localparam logic [3:0]  OS_LAST     = 4'hF;
   localparam logic [3:0]  OS_MID      = 4'h7;
   localparam logic [2:0]  BIT_LAST    = 3'h7;
   localparam int          FIFO_W      = 8;
   localparam int          FIFO_D      = 8;
   // Cycles per 16x tick for a baud rate
   function automatic logic [15:0] tick_div(input int baud);
      tick_div = 16'(CLK_HZ / (baud * OVERSAMPLE));
   endfunction : tick_div
endpackage : console_pkg

// File: verilog/byte_fifo.sv
`timescale 1ns/10ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output      logic             in_ready,
   output      logic [WIDTH-1:0] out_data,
   output      logic             out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];

   always_comb
   begin
      push        = in_valid && in_ready;
      pop         = out_valid && out_ready;
      next_wr_ptr = push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
      next_rd_ptr = pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
      next_count  = count;
      if (push && !pop)
         next_count = count + 1'b1;
      else if (pop && !push)
         next_count = count - 1'b1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // Storage needs no reset
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end
endmodule : byte_fifo

// File: verilog/serial_console.sv
`timescale 1ns/10ps
// Contract
// (RL1) Serial receive data enters on the host transmit line.
// (RL2) Serial transmit data leaves on the host receive line.
// (RL3) Clear-to-send drops when the device wants the host to stop.
// (RL4) Transmitter pauses while host data-terminal-ready is low; code only holds off new frames, one in progress finishes.
// (RL5) Data-set-ready stays asserted whenever powered.
// (RL6) Request-to-send, carrier detect and equipment ground are ignored.
// (RL7) At power-up baud divisor comes from boot ROM byte 0008h.
// (RL8) RAM byte 0008h acts as the active baud divisor.
// (RL9) Divisor codes FF..A0 select 57600 down to 600 baud.
// (RL10) Autoexecute program lives in ROM 2000h to 7FFFh, runs after reset.
// (RL11) Autoexecute recognised only when byte 2000h equals A5.
// (RL12) Autoexecute entry is the byte after the signature.
// (RL13) Framing is 8N1, least significant bit first.
module serial_console
   import console_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic        SERIAL_IN,
   output      logic        SERIAL_OUT,
   output      logic        CLEAR_TO_SEND,
   output      logic        DATA_SET_READY,
   input  wire logic        TERMINAL_READY,
   input  wire logic        REQUEST_TO_SEND,
   output      logic [15:0] BOOT_ADDR,
   output      logic        BOOT_RD,
   input  wire logic [7:0]  BOOT_DATA,
   input  wire logic        DIV_WR,
   input  wire logic [7:0]  DIV_DATA,
   output      logic [7:0]  ACTIVE_DIV,
   output      logic [15:0] START_ADDR,
   output      logic        BOOT_DONE,
   input  wire logic [7:0]  TX_DATA,
   input  wire logic        TX_VALID,
   output      logic        TX_READY,
   output      logic [7:0]  RX_DATA,
   output      logic        RX_VALID,
   input  wire logic        RX_HOLD
);
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      B_DIV  = 2'b00,
      B_SIG  = 2'b01,
      B_WAIT = 2'b10,
      B_DONE = 2'b11
   } boot_t;
   typedef enum logic [1:0] {
      T_IDLE  = 2'b00,
      T_START = 2'b01,
      T_DATA  = 2'b10,
      T_STOP  = 2'b11
   } tx_t;
   typedef enum logic [1:0] {
      R_IDLE  = 2'b00,
      R_START = 2'b01,
      R_DATA  = 2'b10,
      R_STOP  = 2'b11
   } rx_t;

   boot_t       boot;
   boot_t       next_boot;
   logic [7:0]  div_code;
   logic [7:0]  next_div_code;
   logic [15:0] start_addr;
   logic [15:0] next_start_addr;
   logic [15:0] tick_cnt;
   logic [15:0] next_tick_cnt;
   logic [15:0] tick_len;
   logic        tick;
   logic [2:0]  rx_sync;
   logic [1:0]  dtr_sync;
   logic        rx_pin;
   logic        dtr_ok;

   // Receive pin passes three flops, DTR two, before use
   // (RL1) receive pin synchronised
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         rx_sync  <= 3'h7;
         dtr_sync <= 2'h0;
      end
      else
      begin
         rx_sync  <= {rx_sync[1:0], SERIAL_IN};
         dtr_sync <= {dtr_sync[0], TERMINAL_READY};
      end
   end
   assign rx_pin = rx_sync[2];
   assign dtr_ok = dtr_sync[1];

   ////////////////////////////////////////////////////////////////////////
   // Boot sequence: divisor byte, then signature byte
   always_comb
   begin
      next_boot       = boot;
      next_div_code   = div_code;
      next_start_addr = start_addr;
      unique case (boot)
         B_DIV:
         begin
            // (RL7) ROM divisor at power-up
            next_div_code = BOOT_DATA;
            next_boot     = B_SIG;
         end
         B_SIG:
            next_boot = B_WAIT;
         B_WAIT:
         begin
            // (RL11) signature check at 2000h
            // (RL12) entry after signature
            // (RL10) autoexecute after reset
            if (BOOT_DATA == AUTO_SIGNATURE)
               next_start_addr = AUTO_ENTRY_ADDR;
            else
               next_start_addr = MONITOR_ENTRY;
            next_boot = B_DONE;
         end
         B_DONE:
         begin
            // (RL8) RAM copy is the live divisor
            if (DIV_WR)
               next_div_code = DIV_DATA;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         boot       <= B_DIV;
         div_code   <= DIV_9600;
         start_addr <= MONITOR_ENTRY;
      end
      else
      begin
         boot       <= next_boot;
         div_code   <= next_div_code;
         start_addr <= next_start_addr;
      end
   end

   // Address leads data by one cycle; ROM assumed synchronous
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         BOOT_ADDR <= BAUD_DIV_ADDR;
         BOOT_RD   <= 1'b1;
         BOOT_DONE <= 1'b0;
      end
      else
      begin
         BOOT_ADDR <= (next_boot == B_DIV) ? BAUD_DIV_ADDR : AUTO_SIG_ADDR;
         BOOT_RD   <= (next_boot == B_DIV) || (next_boot == B_SIG);
         BOOT_DONE <= (next_boot == B_DONE);
      end
   end
   assign ACTIVE_DIV = div_code;
   assign START_ADDR = start_addr;

   ////////////////////////////////////////////////////////////////////////
   // (RL9) divisor code to tick length
   always_comb
   begin
      unique case (div_code)
         DIV_57600: tick_len = tick_div(57600);
         DIV_28800: tick_len = tick_div(28800);
         DIV_19200: tick_len = tick_div(19200);
         DIV_9600:  tick_len = tick_div(9600);
         DIV_4800:  tick_len = tick_div(4800);
         DIV_2400:  tick_len = tick_div(2400);
         DIV_1200:  tick_len = tick_div(1200);
         DIV_600:   tick_len = tick_div(600);
         // Unlisted codes fall back to 9600
         default:   tick_len = tick_div(9600);
      endcase
   end

   always_comb
   begin
      tick          = (tick_cnt >= tick_len - 16'h0001);
      next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
   end

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         tick_cnt <= 16'h0000;
      else
         tick_cnt <= next_tick_cnt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmitter
   tx_t        tx_st;
   tx_t        next_tx_st;
   logic [7:0] tx_sh;
   logic [7:0] next_tx_sh;
   logic [3:0] tx_os;
   logic [3:0] next_tx_os;
   logic [2:0] tx_bit;
   logic [2:0] next_tx_bit;
   logic       next_serial_out;
   logic [7:0] txf_data;
   logic       txf_valid;
   logic       txf_take;

   always_comb
   begin
      next_tx_st      = tx_st;
      next_tx_sh      = tx_sh;
      next_tx_os      = tx_os;
      next_tx_bit     = tx_bit;
      next_serial_out = SERIAL_OUT;
      txf_take        = 1'b0;
      unique case (tx_st)
         T_IDLE:
         begin
            next_serial_out = 1'b1;
            // (RL4) no new frame while DTR low
            if (tick && txf_valid && dtr_ok && boot == B_DONE)
            begin
               txf_take        = 1'b1;
               next_tx_sh      = txf_data;
               next_tx_os      = 4'h0;
               next_serial_out = 1'b0;
               next_tx_st      = T_START;
            end
         end
         T_START, T_DATA, T_STOP:
         begin
            if (tick)
            begin
               next_tx_os = tx_os + 4'h1;
               if (tx_os == OS_LAST)
               begin
                  // (RL13) LSB first, one stop bit
                  if (tx_st == T_START)
                  begin
                     next_serial_out = tx_sh[0];
                     next_tx_bit     = 3'h0;
                     next_tx_st      = T_DATA;
                  end
                  else if (tx_st == T_DATA)
                  begin
                     next_tx_bit = tx_bit + 3'h1;
                     if (tx_bit == BIT_LAST)
                     begin
                        next_serial_out = 1'b1;
                        next_tx_st      = T_STOP;
                     end
                     else
                     begin
                        next_tx_sh      = {1'b0, tx_sh[7:1]};
                        next_serial_out = tx_sh[1];
                     end
                  end
                  else
                     next_tx_st = T_IDLE;
               end
            end
         end
      endcase
   end

   // (RL2) transmit pin from a flop
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         tx_st      <= T_IDLE;
         tx_sh      <= 8'h00;
         tx_os      <= 4'h0;
         tx_bit     <= 3'h0;
         SERIAL_OUT <= 1'b1;
      end
      else
      begin
         tx_st      <= next_tx_st;
         tx_sh      <= next_tx_sh;
         tx_os      <= next_tx_os;
         tx_bit     <= next_tx_bit;
         SERIAL_OUT <= next_serial_out;
      end
   end

   // Absorbs bursts while the host holds DTR low
   byte_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) tx_fifo (
      .clk       (SYS_CLK),
      .rst       (RST),
      .in_data   (TX_DATA),
      .in_valid  (TX_VALID),
      .in_ready  (TX_READY),
      .out_data  (txf_data),
      .out_valid (txf_valid),
      .out_ready (txf_take)
   );

   ////////////////////////////////////////////////////////////////////////
   // Receiver, centre-sampled at 16x
   rx_t        rx_st;
   rx_t        next_rx_st;
   logic [7:0] rx_sh;
   logic [7:0] next_rx_sh;
   logic [3:0] rx_os;
   logic [3:0] next_rx_os;
   logic [2:0] rx_bit;
   logic [2:0] next_rx_bit;
   logic       rx_push;
   logic       rxf_ready;
   logic       next_cts;

   always_comb
   begin
      next_rx_st  = rx_st;
      next_rx_sh  = rx_sh;
      next_rx_os  = rx_os;
      next_rx_bit = rx_bit;
      rx_push     = 1'b0;
      if (tick)
      begin
         next_rx_os = rx_os + 4'h1;
         unique case (rx_st)
            R_IDLE:
            begin
               next_rx_os = 4'h0;
               if (!rx_pin)
                  next_rx_st = R_START;
            end
            R_START:
               if (rx_os == OS_MID)
               begin
                  next_rx_os  = 4'h0;
                  next_rx_bit = 3'h0;
                  next_rx_st  = rx_pin ? R_IDLE : R_DATA;
               end
            R_DATA:
               if (rx_os == OS_LAST)
               begin
                  // (RL13) LSB arrives first
                  next_rx_sh  = {rx_pin, rx_sh[7:1]};
                  next_rx_bit = rx_bit + 3'h1;
                  if (rx_bit == BIT_LAST)
                     next_rx_st = R_STOP;
               end
            R_STOP:
               if (rx_os == OS_LAST)
               begin
                  // Bad stop bit drops the byte
                  rx_push    = rx_pin;
                  next_rx_st = R_IDLE;
               end
         endcase
      end
      // (RL3) stop host while buffer is full
      next_cts = rxf_ready;
   end

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         rx_st          <= R_IDLE;
         rx_sh          <= 8'h00;
         rx_os          <= 4'h0;
         rx_bit         <= 3'h0;
         CLEAR_TO_SEND  <= 1'b1;
         DATA_SET_READY <= 1'b1;
      end
      else
      begin
         rx_st          <= next_rx_st;
         rx_sh          <= next_rx_sh;
         rx_os          <= next_rx_os;
         rx_bit         <= next_rx_bit;
         CLEAR_TO_SEND  <= next_cts;
         // (RL5) always ready
         DATA_SET_READY <= 1'b1;
      end
   end

   // (RL6) REQUEST_TO_SEND deliberately unused
   byte_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) rx_fifo (
      .clk       (SYS_CLK),
      .rst       (RST),
      .in_data   (rx_sh),
      .in_valid  (rx_push),
      .in_ready  (rxf_ready),
      .out_data  (RX_DATA),
      .out_valid (RX_VALID),
      .out_ready (!RX_HOLD)
   );
endmodule : serial_console

// File: bench/serial_console_checker.sv
`timescale 1ns/10ps
module serial_console_checker
   import console_pkg::*;
(
   input wire logic        SYS_CLK,
   input wire logic        RST,
   input wire logic        SERIAL_IN,
   input wire logic        SERIAL_OUT,
   input wire logic        CLEAR_TO_SEND,
   input wire logic        DATA_SET_READY,
   input wire logic        TERMINAL_READY,
   input wire logic        REQUEST_TO_SEND,
   input wire logic [15:0] BOOT_ADDR,
   input wire logic        BOOT_RD,
   input wire logic [7:0]  BOOT_DATA,
   input wire logic        DIV_WR,
   input wire logic [7:0]  DIV_DATA,
   input wire logic [7:0]  ACTIVE_DIV,
   input wire logic [15:0] START_ADDR,
   input wire logic        BOOT_DONE,
   input wire logic [7:0]  TX_DATA,
   input wire logic        TX_VALID,
   input wire logic        TX_READY,
   input wire logic [7:0]  RX_DATA,
   input wire logic        RX_VALID,
   input wire logic        RX_HOLD
);
   // One frame at the fastest divisor; slower rates skip the pause check
   localparam int FRAME_CYC = 34720;
   logic [15:0] fall_age;
   logic [15:0] next_fall_age;
   logic        out_prev;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_fall_age = fall_age;
      if (out_prev && !SERIAL_OUT)
         next_fall_age = 16'h0000;
      else if (fall_age != 16'hFFFF)
         next_fall_age = fall_age + 16'h0001;
   end

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         fall_age <= 16'hFFFF;
         out_prev <= 1'b1;
      end
      else
      begin
         fall_age <= next_fall_age;
         out_prev <= SERIAL_OUT;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   a_dsr_held: assert property (DATA_SET_READY)
      else $error("data set ready low");
   // Sampled reset keeps the release edge out of the window
   a_div_from_rom: assert property (!RST && !BOOT_DONE && BOOT_RD &&
      BOOT_ADDR == BAUD_DIV_ADDR |=> ACTIVE_DIV == $past(BOOT_DATA))
      else $error("divisor not taken from boot memory");
   a_div_written: assert property (BOOT_DONE && DIV_WR |=>
      ACTIVE_DIV == $past(DIV_DATA))
      else $error("divisor write lost");
   a_entry_legal: assert property (BOOT_DONE |->
      START_ADDR == AUTO_ENTRY_ADDR || START_ADDR == MONITOR_ENTRY)
      else $error("start address illegal");
   a_done_kept: assert property (BOOT_DONE |=> BOOT_DONE)
      else $error("boot done dropped");
   a_quiet_boot: assert property (!BOOT_DONE |-> SERIAL_OUT)
      else $error("line active before boot done");
   a_cts_empty: assert property (!RX_VALID |-> CLEAR_TO_SEND)
      else $error("clear to send low with empty queue");
   a_rx_held: assert property (RX_VALID && RX_HOLD |=>
      RX_VALID && $stable(RX_DATA))
      else $error("held byte changed");
   a_dtr_pause: assert property ((!TERMINAL_READY [*6]) ##0
      (ACTIVE_DIV == DIV_57600 && fall_age > FRAME_CYC) |=> SERIAL_OUT)
      else $error("frame started while paused");
endmodule : serial_console_checker

// File: bench/host_terminal.sv
`timescale 1ns/10ps
module host_terminal #(
   parameter int BIT_CYC = 3472
) (
   input  wire logic clk,
   input  wire logic dev_out,
   input  wire logic dev_cts,
   output      logic host_out,
   output      logic host_dtr
);
   // Line idles at mark; device starts paused
   initial
   begin
      host_out = 1'b1;
      host_dtr = 1'b0;
   end

   task automatic set_ready(input logic v);
      @(posedge clk);
      host_dtr <= v;
   endtask : set_ready

   task automatic put_byte(input logic [7:0] b, output logic ok);
      int n;
      ok = 1'b0;
      for (n = 0; n < 100000 && dev_cts !== 1'b1; n++)
         @(posedge clk);
      if (dev_cts !== 1'b1)
         return;
      ok = 1'b1;
      for (n = 0; n < 10; n++)
      begin
         @(posedge clk);
         host_out <= (n == 0) ? 1'b0 : (n == 9) ? 1'b1 : b[n - 1];
         repeat (BIT_CYC - 1) @(posedge clk);
      end
   endtask : put_byte

   task automatic get_byte(output logic [7:0] b, output logic ok);
      int n;
      ok = 1'b0;
      b = 8'h00;
      for (n = 0; n < 20000 && dev_out !== 1'b0; n++)
         @(posedge clk);
      if (dev_out !== 1'b0)
         return;
      repeat (BIT_CYC / 2) @(posedge clk);
      ok = (dev_out === 1'b0);
      for (n = 0; n < 8; n++)
      begin
         repeat (BIT_CYC) @(posedge clk);
         b[n] = dev_out;
      end
      repeat (BIT_CYC) @(posedge clk);
      ok = ok && (dev_out === 1'b1);
   endtask : get_byte
endmodule : host_terminal

// File: bench/tb_serial_console.sv
`timescale 1ns/10ps
module tb_serial_console;
   import console_pkg::*;
   localparam int BIT_CYC = 3472;
   // Start bit plus a zero first data bit at 28800 baud
   localparam int RUN_28800 = 2 * OVERSAMPLE * (CLK_HZ / (28800 * OVERSAMPLE));
   logic        sys_clk, rst, serial_in, serial_out, cts, dsr, dtr, rts;
   logic        boot_rd, div_wr, boot_done, tx_valid, tx_ready;
   logic        rx_valid, rx_hold, ok;
   logic [15:0] boot_addr, start_addr;
   logic [7:0]  boot_data, div_data, active_div, tx_data, rx_data;
   logic [7:0]  rom_div, rom_sig, got;
   logic [7:0]  codes [8] = '{DIV_57600, DIV_28800, DIV_19200, DIV_9600,
                              DIV_4800, DIV_2400, DIV_1200, DIV_600};
   int          mismatches, samples_checked;

   serial_console serial_console_i (
      .SYS_CLK(sys_clk), .RST(rst), .SERIAL_IN(serial_in),
      .SERIAL_OUT(serial_out), .CLEAR_TO_SEND(cts), .DATA_SET_READY(dsr),
      .TERMINAL_READY(dtr), .REQUEST_TO_SEND(rts), .BOOT_ADDR(boot_addr),
      .BOOT_RD(boot_rd), .BOOT_DATA(boot_data), .DIV_WR(div_wr),
      .DIV_DATA(div_data), .ACTIVE_DIV(active_div),
      .START_ADDR(start_addr), .BOOT_DONE(boot_done), .TX_DATA(tx_data),
      .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_DATA(rx_data),
      .RX_VALID(rx_valid), .RX_HOLD(rx_hold));
   host_terminal #(.BIT_CYC(BIT_CYC)) host_terminal_i (
      .clk(sys_clk), .dev_out(serial_out), .dev_cts(cts),
      .host_out(serial_in), .host_dtr(dtr));

   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Boot memory answers one cycle after the address
   always_ff @(posedge sys_clk)
      if (boot_rd)
         boot_data <= (boot_addr == BAUD_DIV_ADDR) ? rom_div :
                      (boot_addr == AUTO_SIG_ADDR) ? rom_sig : 8'h00;

   ////////////////////////////////////////////////////////////////////////
   task automatic check_val(input string what, input logic [15:0] e, s);
      samples_checked++;
      if (e !== s)
      begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, e, s);
      end
   endtask : check_val

   task automatic check_bit(input string what, input logic e, s);
      check_val(what, {15'h0000, e}, {15'h0000, s});
   endtask : check_bit

   task automatic give_verdict;
      $display("checked %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////
   // Writes during boot must be dropped
   task automatic boot_run(input logic [7:0] d, s, input logic [15:0] a);
      int n;
      @(posedge sys_clk);
      rom_div <= d;
      rom_sig <= s;
      rst <= 1'b1;
      div_wr <= 1'b1;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      div_wr <= 1'b0;
      for (n = 0; n < 20 && boot_done !== 1'b1; n++)
      begin
         @(posedge sys_clk);
         #1;
      end
      check_bit("boot done", 1'b1, boot_done);
      if (boot_done !== 1'b1)
         give_verdict();
      check_val("divisor", {8'h00, d}, {8'h00, active_div});
      check_val("entry", a, start_addr);
      check_bit("data set ready", 1'b1, dsr);
   endtask : boot_run

   task automatic div_write(input logic [7:0] d);
      @(posedge sys_clk);
      div_wr <= 1'b1;
      div_data <= d;
      @(posedge sys_clk);
      div_wr <= 1'b0;
      @(posedge sys_clk);
      #1;
      check_val("ram divisor", {8'h00, d}, {8'h00, active_div});
   endtask : div_write

   task automatic tx_flow;
      int n;
      for (n = 0; n < 8; n++)
      begin
         @(posedge sys_clk);
         tx_data <= 8'h35 + 8'(n);
         tx_valid <= 1'b1;
      end
      @(posedge sys_clk);
      tx_valid <= 1'b0;
      #1;
      check_bit("tx ready full", 1'b0, tx_ready);
      repeat (2000) @(posedge sys_clk);
      check_bit("paused line", 1'b1, serial_out);
      host_terminal_i.set_ready(1'b1);
      fork
         host_terminal_i.get_byte(got, ok);
         begin
            repeat (400) @(posedge sys_clk);
            host_terminal_i.set_ready(1'b0);
         end
      join
      check_bit("tx framing", 1'b1, ok);
      if (ok !== 1'b1)
         give_verdict();
      check_val("tx byte", 16'h0035, {8'h00, got});
      n = 0;
      repeat (2 * BIT_CYC)
      begin
         @(posedge sys_clk);
         if (serial_out !== 1'b1)
            n++;
      end
      check_val("low cycles", 16'h0000, 16'(n));
   endtask : tx_flow

   // Next queued byte 36h goes out at 28800; its low run sets the rate
   task automatic rate_check;
      int n;
      div_write(DIV_28800);
      host_terminal_i.set_ready(1'b1);
      for (n = 0; n < 2000 && serial_out !== 1'b0; n++)
         @(posedge sys_clk);
      check_bit("start bit", 1'b0, serial_out);
      for (n = 0; n < 20000 && serial_out === 1'b0; n++)
         @(posedge sys_clk);
      check_val("low run", 16'(RUN_28800), 16'(n));
      if (n == 0 || n >= 20000)
         give_verdict();
      // Reset cuts the frame short and brings back the fast rate
      boot_run(DIV_57600, AUTO_SIGNATURE, AUTO_ENTRY_ADDR);
   endtask : rate_check

   task automatic rx_path;
      int n;
      @(posedge sys_clk);
      rts <= 1'b0;
      rx_hold <= 1'b1;
      host_terminal_i.put_byte(8'hC9, ok);
      check_bit("host allowed", 1'b1, ok);
      for (n = 0; n < 1000 && rx_valid !== 1'b1; n++)
      begin
         @(posedge sys_clk);
         #1;
      end
      check_bit("rx valid", 1'b1, rx_valid);
      if (rx_valid !== 1'b1)
         give_verdict();
      check_val("rx byte", 16'h00C9, {8'h00, rx_data});
      check_bit("clear to send", 1'b1, cts);
      @(posedge sys_clk);
      rx_hold <= 1'b0;
      @(posedge sys_clk);
      #1;
      check_bit("rx popped", 1'b0, rx_valid);
   endtask : rx_path

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst = 1'b1;
      rts = 1'b1;
      div_wr = 1'b0;
      div_data = 8'h00;
      tx_data = 8'h00;
      tx_valid = 1'b0;
      rx_hold = 1'b0;
      rom_div = 8'hFA;
      rom_sig = 8'h00;
      mismatches = 0;
      samples_checked = 0;
      foreach (codes[i])
         boot_run(codes[i], 8'hA4, MONITOR_ENTRY);
      boot_run(DIV_57600, AUTO_SIGNATURE, AUTO_ENTRY_ADDR);
      div_write(DIV_1200);
      div_write(DIV_57600);
      tx_flow();
      rate_check();
      rx_path();
      give_verdict();
   end
endmodule : tb_serial_console

bind serial_console serial_console_checker serial_console_checker_i (
   .SYS_CLK(SYS_CLK), .RST(RST), .SERIAL_IN(SERIAL_IN),
   .SERIAL_OUT(SERIAL_OUT), .CLEAR_TO_SEND(CLEAR_TO_SEND),
   .DATA_SET_READY(DATA_SET_READY), .TERMINAL_READY(TERMINAL_READY),
   .REQUEST_TO_SEND(REQUEST_TO_SEND), .BOOT_ADDR(BOOT_ADDR),
   .BOOT_RD(BOOT_RD), .BOOT_DATA(BOOT_DATA), .DIV_WR(DIV_WR),
   .DIV_DATA(DIV_DATA), .ACTIVE_DIV(ACTIVE_DIV), .START_ADDR(START_ADDR),
   .BOOT_DONE(BOOT_DONE), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
   .TX_READY(TX_READY), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
   .RX_HOLD(RX_HOLD));
